// ---- hdl/cvsd_pcm_status_flags.v ----
// Purpose: Status flags and service requests of the CVSD/PCM converter
// Assumes: All inputs synchronous to i_clock; control bits held by caller
// Notes:   Read strobe is one cycle per status read
`timescale 1ns/1ps
`default_nettype none
`include "cvsd_status_defines.vh"

module cvsd_pcm_status_flags #(
   parameter WIDTH     = `FIFO_WORD_WIDTH,
   parameter DEPTH     = `FIFO_DEPTH,
   parameter CNT_WIDTH = `FIFO_CNT_WIDTH
)(
   input  wire                   i_clock,
   input  wire                   i_rstn,
   // Control bits
   input  wire                   i_converter_enable,
   input  wire                   i_freeze,
   input  wire                   i_fifo_level_irq_enable,
   input  wire                   i_fifo_error_irq_enable,
   input  wire                   i_pcm_irq_enable,
   input  wire                   i_in_fifo_dma_enable,
   input  wire                   i_out_fifo_dma_enable,
   // Status register read port
   input  wire                   i_status_rd,
   output wire [`STAT_WIDTH-1:0] o_converter_status,
   // Bus side of the CVSD FIFOs
   input  wire                   i_cvsd_in_wr,
   input  wire [WIDTH-1:0]       i_cvsd_in_data,
   input  wire                   i_cvsd_out_rd,
   output wire [WIDTH-1:0]       o_cvsd_out_data,
   // Core side of the CVSD FIFOs
   input  wire                   i_core_in_rd,
   output wire [WIDTH-1:0]       o_core_in_data,
   input  wire                   i_core_out_wr,
   input  wire [WIDTH-1:0]       i_core_out_data,
   // PCM holding registers
   input  wire                   i_pcm_in_wr,
   input  wire [WIDTH-1:0]       i_pcm_in_data,
   input  wire                   i_core_pcm_in_rd,
   output reg  [WIDTH-1:0]       o_core_pcm_in_data,
   input  wire                   i_core_pcm_out_wr,
   input  wire [WIDTH-1:0]       i_core_pcm_out_data,
   input  wire                   i_pcm_out_rd,
   output reg  [WIDTH-1:0]       o_pcm_output_holding,
   // Requests
   output wire                   o_irq,
   output wire                   o_in_fifo_dma_req,
   output wire                   o_out_fifo_dma_req
);

   // --------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------
   wire                 flush;
   wire                 core_in_pop;
   wire                 core_out_push;
   wire                 in_full;
   wire                 in_empty;
   wire                 out_full;
   wire                 out_empty;
   wire [CNT_WIDTH-1:0] in_count;
   wire [CNT_WIDTH-1:0] out_count;
   reg  [CNT_WIDTH-1:0] in_count_prev_q;
   reg  [CNT_WIDTH-1:0] out_count_prev_q;
   wire                 ne_event;
   wire                 nf_event;
   wire                 ur_event;
   wire                 or_event;
   wire                 pcm_event;
   wire                 clear_level;
   wire                 clear_sticky;

   reg                  in_fifo_nearly_empty_q;
   reg                  in_fifo_nearly_empty_d;
   reg                  out_fifo_nearly_full_q;
   reg                  out_fifo_nearly_full_d;
   reg                  pcm_service_flag_q;
   reg                  pcm_service_flag_d;
   reg                  in_fifo_underrun_q;
   reg                  in_fifo_underrun_d;
   reg                  out_fifo_overrun_q;
   reg                  out_fifo_overrun_d;

   reg                  pcm_out_full_q;
   reg                  pcm_in_empty_q;
   wire                 pcm_out_load;
   wire                 pcm_in_take;

   reg  [2:0]           in_fifo_free_count;
   reg  [2:0]           out_fifo_fill_count;
   wire [CNT_WIDTH-1:0] in_free_words;

   // Disabling the converter returns the block to reset, except the PCM input data and FIFO read data registers
   assign flush = ~i_converter_enable;

   // --------------------------------------------------------------
   // Core access gating
   // --------------------------------------------------------------
   // Freeze halts the core's FIFO accesses and PCM output loads; core PCM input reads still take
   assign core_in_pop   = i_core_in_rd & ~i_freeze;
   assign core_out_push = i_core_out_wr & ~i_freeze;
   assign pcm_out_load  = i_core_pcm_out_wr & ~i_freeze;
   assign pcm_in_take   = i_core_pcm_in_rd & ~pcm_in_empty_q;

   // --------------------------------------------------------------
   // CVSD FIFOs
   // --------------------------------------------------------------
   cvsd_word_fifo #(
      .WIDTH     (WIDTH),
      .DEPTH     (DEPTH),
      .CNT_WIDTH (CNT_WIDTH)
   ) u_in_fifo (
      .i_clock (i_clock),
      .i_rstn  (i_rstn),
      .i_flush (flush),
      .i_push  (i_cvsd_in_wr),
      .i_wdata (i_cvsd_in_data),
      .i_pop   (core_in_pop),
      .o_rdata (o_core_in_data),
      .o_count (in_count),
      .o_full  (in_full),
      .o_empty (in_empty)
   );

   cvsd_word_fifo #(
      .WIDTH     (WIDTH),
      .DEPTH     (DEPTH),
      .CNT_WIDTH (CNT_WIDTH)
   ) u_out_fifo (
      .i_clock (i_clock),
      .i_rstn  (i_rstn),
      .i_flush (flush),
      .i_push  (core_out_push),
      .i_wdata (i_core_out_data),
      .i_pop   (i_cvsd_out_rd),
      .o_rdata (o_cvsd_out_data),
      .o_count (out_count),
      .o_full  (out_full),
      .o_empty (out_empty)
   );

   // --------------------------------------------------------------
   // Event detection
   // --------------------------------------------------------------
   always @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         in_count_prev_q  <= {CNT_WIDTH{1'b0}};
         out_count_prev_q <= {CNT_WIDTH{1'b0}};
      end
      else
      begin
         in_count_prev_q  <= in_count;
         out_count_prev_q <= out_count;
      end
   end

   // Edge-triggered so a read clear is not instantly undone
   assign ne_event = (in_count == `NEAR_WORDS)
                     & (in_count_prev_q != `NEAR_WORDS);
   assign nf_event = (out_count == DEPTH[CNT_WIDTH-1:0] - `NEAR_WORDS)
                     & (out_count_prev_q
                        != DEPTH[CNT_WIDTH-1:0] - `NEAR_WORDS);
   assign ur_event  = core_in_pop & in_empty;
   assign or_event  = core_out_push & out_full;
   assign pcm_event = pcm_out_load | pcm_in_take;

   // Level flags clear on any read; sticky ones hold in freeze
   assign clear_level  = i_status_rd;
   assign clear_sticky = i_status_rd & ~i_freeze;

   // --------------------------------------------------------------
   // Flag next state: a set in the clearing cycle wins
   // --------------------------------------------------------------
   always @*
   begin
      in_fifo_nearly_empty_d = in_fifo_nearly_empty_q;
      out_fifo_nearly_full_d = out_fifo_nearly_full_q;
      pcm_service_flag_d     = pcm_service_flag_q;
      in_fifo_underrun_d     = in_fifo_underrun_q;
      out_fifo_overrun_d     = out_fifo_overrun_q;
      if (clear_level)
      begin
         in_fifo_nearly_empty_d = 1'b0;
         out_fifo_nearly_full_d = 1'b0;
      end
      if (clear_sticky)
      begin
         pcm_service_flag_d = 1'b0;
         in_fifo_underrun_d = 1'b0;
         out_fifo_overrun_d = 1'b0;
      end
      if (ne_event)
      begin
         in_fifo_nearly_empty_d = 1'b1;
      end
      if (nf_event)
      begin
         out_fifo_nearly_full_d = 1'b1;
      end
      if (pcm_event)
      begin
         pcm_service_flag_d = 1'b1;
      end
      if (ur_event)
      begin
         in_fifo_underrun_d = 1'b1;
      end
      if (or_event)
      begin
         out_fifo_overrun_d = 1'b1;
      end
   end

   // --------------------------------------------------------------
   // Flag registers
   // --------------------------------------------------------------
   always @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         in_fifo_nearly_empty_q <= 1'b0;
         out_fifo_nearly_full_q <= 1'b0;
         pcm_service_flag_q     <= 1'b0;
         in_fifo_underrun_q     <= 1'b0;
         out_fifo_overrun_q     <= 1'b0;
      end
      else if (flush)
      begin
         in_fifo_nearly_empty_q <= 1'b0;
         out_fifo_nearly_full_q <= 1'b0;
         pcm_service_flag_q     <= 1'b0;
         in_fifo_underrun_q     <= 1'b0;
         out_fifo_overrun_q     <= 1'b0;
      end
      else
      begin
         in_fifo_nearly_empty_q <= in_fifo_nearly_empty_d;
         out_fifo_nearly_full_q <= out_fifo_nearly_full_d;
         pcm_service_flag_q     <= pcm_service_flag_d;
         in_fifo_underrun_q     <= in_fifo_underrun_d;
         out_fifo_overrun_q     <= out_fifo_overrun_d;
      end
   end

   // --------------------------------------------------------------
   // PCM holding registers
   // --------------------------------------------------------------
   // Double buffering gives software a full sample period to respond
   always @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_pcm_output_holding <= {WIDTH{1'b0}};
         o_core_pcm_in_data   <= {WIDTH{1'b0}};
         pcm_out_full_q       <= 1'b0;
         pcm_in_empty_q       <= 1'b1;
      end
      else if (flush)
      begin
         o_pcm_output_holding <= {WIDTH{1'b0}};
         pcm_out_full_q       <= 1'b0;
         pcm_in_empty_q       <= 1'b1;
      end
      else
      begin
         if (pcm_out_load)
         begin
            o_pcm_output_holding <= i_core_pcm_out_data;
            pcm_out_full_q       <= 1'b1;
         end
         else if (i_pcm_out_rd)
         begin
            pcm_out_full_q <= 1'b0;
         end
         if (i_pcm_in_wr)
         begin
            o_core_pcm_in_data <= i_pcm_in_data;
            pcm_in_empty_q     <= 1'b0;
         end
         else if (pcm_in_take)
         begin
            pcm_in_empty_q <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------
   // Count fields
   // --------------------------------------------------------------
   // Three bits cannot show eight, so the ends saturate
   assign in_free_words = DEPTH[CNT_WIDTH-1:0] - in_count;
   always @*
   begin
      if (in_count >= `COUNT_SAT_LEVEL)
      begin
         in_fifo_free_count = 3'h0;
      end
      else if (in_count == {CNT_WIDTH{1'b0}})
      begin
         in_fifo_free_count = `COUNT_FIELD_MAX;
      end
      else
      begin
         in_fifo_free_count = in_free_words[2:0];
      end
   end

   always @*
   begin
      if (out_count >= `COUNT_SAT_LEVEL)
      begin
         out_fifo_fill_count = `COUNT_FIELD_MAX;
      end
      else
      begin
         out_fifo_fill_count = out_count[2:0];
      end
   end

   // --------------------------------------------------------------
   // Status register
   // --------------------------------------------------------------
   // Counts are live; with the FIFOs flushed the free count reads 7,
   // not zero, so force the reset value while disabled
   assign o_converter_status = flush ? `STAT_RESET : {
      5'h00,
      out_fifo_fill_count,
      in_fifo_free_count,
      out_fifo_overrun_q,
      in_fifo_underrun_q,
      pcm_service_flag_q,
      out_fifo_nearly_full_q,
      in_fifo_nearly_empty_q
   };

   // --------------------------------------------------------------
   // Interrupt and DMA requests
   // --------------------------------------------------------------
   assign o_irq = ~flush & (
      ((in_fifo_nearly_empty_q | out_fifo_nearly_full_q)
         & i_fifo_level_irq_enable)
      | ((in_fifo_underrun_q | out_fifo_overrun_q)
         & i_fifo_error_irq_enable)
      | (pcm_service_flag_q & i_pcm_irq_enable));

   assign o_in_fifo_dma_req  = ~flush & in_fifo_nearly_empty_q
                               & i_in_fifo_dma_enable;
   assign o_out_fifo_dma_req = ~flush & out_fifo_nearly_full_q
                               & i_out_fifo_dma_enable;

endmodule // cvsd_pcm_status_flags

`default_nettype wire

// ---- hdl/cvsd_status_defines.vh ----
// Purpose: Constants for the converter status and service-request logic
// Assumes: Included by bare name from the design files
// Notes:   Offsets, field positions, reset values and thresholds
`ifndef CVSD_STATUS_DEFINES_VH
`define CVSD_STATUS_DEFINES_VH

// ----------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------
`define STAT_WIDTH        16
`define STAT_RESET        16'h0000
`define STAT_NEARLY_EMPTY 0
`define STAT_NEARLY_FULL  1
`define STAT_PCM_SERVICE  2
`define STAT_UNDERRUN     3
`define STAT_OVERRUN      4
`define STAT_FREE_LSB     5
`define STAT_FREE_MSB     7
`define STAT_FILL_LSB     8
`define STAT_FILL_MSB     10
`define STAT_RSVD_LSB     11
`define STAT_RSVD_MSB     15

// ----------------------------------------------------------------
// FIFO geometry and thresholds
// ----------------------------------------------------------------
`define FIFO_WORD_WIDTH   16
`define FIFO_DEPTH        8
`define FIFO_CNT_WIDTH    4
`define NEAR_WORDS        4'h3
`define COUNT_FIELD_MAX   3'h7
`define COUNT_SAT_LEVEL   4'h7

`endif

// ---- hdl/cvsd_word_fifo.v ----
// Purpose: Word FIFO used for the CVSD input and output streams
// Assumes: Single clock; a push when full or a pop when empty is ignored
// Notes:   Read data is registered on a pop
`timescale 1ns/1ps
`default_nettype none

module cvsd_word_fifo #(
   parameter WIDTH     = 16,
   parameter DEPTH     = 8,
   parameter CNT_WIDTH = 4
)(
   input  wire             i_clock,
   input  wire             i_rstn,
   input  wire             i_flush,
   input  wire             i_push,
   input  wire [WIDTH-1:0] i_wdata,
   input  wire             i_pop,
   output reg  [WIDTH-1:0] o_rdata,
   output reg  [CNT_WIDTH-1:0] o_count,
   output wire             o_full,
   output wire             o_empty
);

   localparam PTR_W = CNT_WIDTH - 1;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [PTR_W-1:0] wr_ptr_q;
   reg [PTR_W-1:0] rd_ptr_q;
   wire            do_push;
   wire            do_pop;

   assign o_full  = (o_count == DEPTH[CNT_WIDTH-1:0]);
   assign o_empty = (o_count == {CNT_WIDTH{1'b0}});
   assign do_push = i_push & ~o_full;
   assign do_pop  = i_pop & ~o_empty;

   // --------------------------------------------------------------
   // Storage: no reset, contents are don't-care until written
   // --------------------------------------------------------------
   always @(posedge i_clock)
   begin
      if (do_push)
      begin
         mem[wr_ptr_q] <= i_wdata;
      end
   end

   // --------------------------------------------------------------
   // Pointers, count and read register
   // --------------------------------------------------------------
   always @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         wr_ptr_q <= {PTR_W{1'b0}};
         rd_ptr_q <= {PTR_W{1'b0}};
         o_count  <= {CNT_WIDTH{1'b0}};
         o_rdata  <= {WIDTH{1'b0}};
      end
      else if (i_flush)
      begin
         wr_ptr_q <= {PTR_W{1'b0}};
         rd_ptr_q <= {PTR_W{1'b0}};
         o_count  <= {CNT_WIDTH{1'b0}};
      end
      else
      begin
         if (do_push)
         begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (do_pop)
         begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
            o_rdata  <= mem[rd_ptr_q];
         end
         if (do_push & ~do_pop)
         begin
            o_count <= o_count + 1'b1;
         end
         else if (do_pop & ~do_push)
         begin
            o_count <= o_count - 1'b1;
         end
      end
   end

endmodule // cvsd_word_fifo

`default_nettype wire

// ---- verification/cvsd_pcm_status_flags_sva.sv ----
// Purpose: Port assertions for the converter status flag block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the block from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module cvsd_pcm_status_flags_sva (
   input wire logic        i_clock,
   input wire logic        i_rstn,
   input wire logic        i_converter_enable,
   input wire logic        i_freeze,
   input wire logic        i_fifo_level_irq_enable,
   input wire logic        i_fifo_error_irq_enable,
   input wire logic        i_pcm_irq_enable,
   input wire logic        i_in_fifo_dma_enable,
   input wire logic        i_out_fifo_dma_enable,
   input wire logic        i_status_rd,
   input wire logic [15:0] o_converter_status,
   input wire logic        i_cvsd_in_wr,
   input wire logic        i_core_in_rd,
   input wire logic        i_core_pcm_out_wr,
   input wire logic        o_irq,
   input wire logic        o_in_fifo_dma_req,
   input wire logic        o_out_fifo_dma_req
);
   // ---------------------------------------------------------------
   // Relations between ports
   // ---------------------------------------------------------------
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   // Count fields; a set flag is tied to the count reaching its level
   wire [2:0] fr = o_converter_status[7:5];
   wire [2:0] fl = o_converter_status[10:8];

   disabled_zero_a: assert property (!i_converter_enable && !$past(i_converter_enable)
      |-> o_converter_status == 16'h0000 && !o_irq) else $error("Output set while disabled");
   rsvd_bits_zero_a: assert property (o_converter_status[15:11] == 5'h00)
      else $error("Reserved status bits set");
   in_dma_follow_a: assert property (o_in_fifo_dma_req ==
      (o_converter_status[0] && i_in_fifo_dma_enable)) else $error("Input request wrong");
   out_dma_follow_a: assert property (o_out_fifo_dma_req ==
      (o_converter_status[1] && i_out_fifo_dma_enable)) else $error("Output request wrong");
   irq_or_a: assert property (o_irq ==
      ((|o_converter_status[1:0] && i_fifo_level_irq_enable)
      || (|o_converter_status[4:3] && i_fifo_error_irq_enable)
      || (o_converter_status[2] && i_pcm_irq_enable))) else $error("Interrupt mismatch");
   ne_read_clear_a: assert property (i_status_rd && i_converter_enable
      && !(fr == 3'h5 && $past(fr) != 3'h5) |=> !o_converter_status[0])
      else $error("Nearly-empty survived a read");
   frz_keep_err_a: assert property (i_status_rd && i_freeze && o_converter_status[3]
      |=> o_converter_status[3] || !i_converter_enable) else $error("Underrun lost in freeze");
   ne_set_a: assert property (i_converter_enable && fr == 3'h5 && $past(fr) != 3'h5
      |=> o_converter_status[0] || !i_converter_enable) else $error("Nearly-empty not set");
   nf_set_a: assert property (i_converter_enable && fl == 3'h5 && $past(fl) != 3'h5
      |=> o_converter_status[1] || !i_converter_enable) else $error("Nearly-full not set");
   pcm_set_a: assert property (i_converter_enable && !i_freeze && i_core_pcm_out_wr
      && !i_status_rd ##1 !i_status_rd |=> o_converter_status[2] || !i_converter_enable)
      else $error("PCM service not set");
   frz_no_pop_a: assert property (i_converter_enable && i_freeze && i_core_in_rd
      && !i_cvsd_in_wr |=> fr == $past(fr) || !i_converter_enable)
      else $error("Core popped input in freeze");
endmodule // cvsd_pcm_status_flags_sva
`default_nettype wire

// ---- verification/cvsd_pcm_status_flags_tb.sv ----
// Purpose: Self-checking bench for the converter status flag block
// Assumes: Expected words are queued by the driver, checked at each bench read
// Notes:   Partner model services DMA requests in the last test only
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module cvsd_pcm_status_flags_tb;
   // ---------------------------------------------------------------
   // Stimulus and design
   // ---------------------------------------------------------------
   logic        i_clock;
   logic        i_rstn;
   logic [6:0]  ctl;
   logic [7:0]  stb;
   logic [15:0] wd;
   logic        tb_rd, dma_go, m_push, m_pop, m_rd;
   logic [3:0]  dma_wait;
   logic [18:0] exp_w;
   logic [18:0] q[$];
   wire  [15:0] stat;
   wire  [15:0] cin_d, cout_d, pin_d, pout_d;
   logic [15:0] wsave;
   wire         irq, in_req, out_req;
   int          err_total;
   int          comparisons;

   cvsd_pcm_status_flags u_cvsd_pcm_status_flags (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_converter_enable(ctl[0]), .i_freeze(ctl[1]),
      .i_fifo_level_irq_enable(ctl[2]), .i_fifo_error_irq_enable(ctl[3]),
      .i_pcm_irq_enable(ctl[4]), .i_in_fifo_dma_enable(ctl[5]), .i_out_fifo_dma_enable(ctl[6]),
      .i_status_rd(tb_rd | m_rd), .o_converter_status(stat),
      .i_cvsd_in_wr(stb[0] | m_push), .i_cvsd_in_data(wd),
      .i_cvsd_out_rd(stb[1] | m_pop), .o_cvsd_out_data(cout_d),
      .i_core_in_rd(stb[2]), .o_core_in_data(cin_d), .i_core_out_wr(stb[3]), .i_core_out_data(wd),
      .i_pcm_in_wr(stb[4]), .i_pcm_in_data(wd), .i_core_pcm_in_rd(stb[5]),
      .o_core_pcm_in_data(pin_d), .i_core_pcm_out_wr(stb[6]), .i_core_pcm_out_data(wd),
      .i_pcm_out_rd(stb[7]), .o_pcm_output_holding(pout_d), .o_irq(irq),
      .o_in_fifo_dma_req(in_req), .o_out_fifo_dma_req(out_req));
   dma_host_model u_dma_host_model (.i_clock(i_clock), .i_go(dma_go), .i_wait(dma_wait),
      .i_in_req(in_req), .i_out_req(out_req), .i_status(stat), .o_push(m_push), .o_pop(m_pop),
      .o_status_rd(m_rd));

   initial
   begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   // Only the bench's own reads are checked; partner reads carry no note
   always @(posedge i_clock)
   begin
      if (tb_rd)
      begin
         exp_w = q.pop_front();
         `CHK({irq, in_req, out_req, stat}, exp_w)
      end
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic pulse(input int b, input int n);
      repeat (n)
      begin
         stb[b] <= 1'b1;
         wd     <= 16'($urandom);
         @(posedge i_clock);
      end
      stb[b] <= 1'b0;
      @(posedge i_clock);
   endtask
   task automatic set_ctl(input logic [6:0] v);
      ctl <= v;
      @(posedge i_clock);
   endtask
   // Expected word: requests and status worked out from flags and counts
   task automatic rd(input logic [4:0] f, input int ic, input int oc);
      logic [15:0] s;
      logic [2:0]  fr;
      fr = (ic == 0) ? 3'h7 : (ic >= 7) ? 3'h0 : 3'(8 - ic);
      s  = ctl[0] ? {5'h00, ((oc >= 7) ? 3'h7 : 3'(oc)), fr, f} : 16'h0000;
      q.push_back({((s[0] | s[1]) & ctl[2]) | ((s[3] | s[4]) & ctl[3]) | (s[2] & ctl[4]),
                   s[0] & ctl[5], s[1] & ctl[6], s});
      tb_rd <= 1'b1;
      @(posedge i_clock);
      tb_rd <= 1'b0;
      @(posedge i_clock);
   endtask
   // Waits for a request to be raised and then served by the partner
   task automatic wait_idle();
      int seen;
      seen = 0;
      for (int i = 0; i < 64; i++)
      begin
         @(posedge i_clock);
         if (in_req || out_req)
            seen = 1;
         else if (seen && !m_rd)
            return;
      end
      err_total++;
      $display("MISMATCH t=%0t request never served", $time);
      final_report();
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      i_rstn      = 1'b0;
      ctl         = 7'h00;
      stb         = 8'h00;
      wd          = 16'h0000;
      tb_rd       = 1'b0;
      dma_go      = 1'b0;
      dma_wait    = 4'h0;
      err_total   = 0;
      comparisons = 0;
      void'($urandom(86493));
      repeat (3) @(posedge i_clock);
      i_rstn <= 1'b1;
      @(posedge i_clock);
      rd(5'h00, 0, 0);
      pulse(0, 2);
      rd(5'h00, 0, 0);
      $display("test disabled done");
      set_ctl(7'h6d);
      pulse(0, 2);
      rd(5'h00, 2, 0);
      pulse(0, 1);
      rd(5'h01, 3, 0);
      rd(5'h00, 3, 0);
      pulse(0, 6);
      rd(5'h00, 8, 0);
      pulse(2, 8);
      rd(5'h01, 0, 0);
      pulse(2, 1);
      set_ctl(ctl | 7'h02);
      pulse(0, 2);
      pulse(2, 1);
      rd(5'h08, 2, 0);
      rd(5'h08, 2, 0);
      set_ctl(ctl & 7'h7d);
      rd(5'h08, 2, 0);
      rd(5'h00, 2, 0);
      $display("test input fifo done");
      pulse(3, 5);
      rd(5'h02, 2, 5);
      rd(5'h00, 2, 5);
      pulse(3, 4);
      rd(5'h10, 2, 8);
      set_ctl(ctl & 7'h77);
      pulse(3, 1);
      rd(5'h10, 2, 8);
      rd(5'h00, 2, 8);
      set_ctl(ctl | 7'h08);
      pulse(1, 8);
      rd(5'h02, 2, 0);
      $display("test output fifo done");
      pulse(6, 1);
      `CHK(pout_d, wd)
      rd(5'h04, 2, 0);
      set_ctl(ctl | 7'h10);
      pulse(6, 1);
      set_ctl(ctl | 7'h02);
      rd(5'h04, 2, 0);
      rd(5'h04, 2, 0);
      set_ctl(ctl & 7'h7d);
      rd(5'h04, 2, 0);
      set_ctl(ctl | 7'h02);
      wsave = pout_d;
      pulse(6, 1);
      `CHK(pout_d, wsave)
      rd(5'h00, 2, 0);
      set_ctl(ctl & 7'h7d);
      pulse(4, 1);
      `CHK(pin_d, wd)
      pulse(5, 1);
      rd(5'h04, 2, 0);
      pulse(7, 1);
      rd(5'h00, 2, 0);
      $display("test pcm done");
      pulse(2, 3);
      set_ctl(ctl & 7'h7e);
      rd(5'h00, 0, 0);
      set_ctl(ctl | 7'h01);
      rd(5'h00, 0, 0);
      $display("test disable done");
      // Every fill level, so each count field value except a free count of 1 is seen at least once
      for (int k = 0; k <= 8; k++)
      begin
         pulse(0, k);
         pulse(3, k);
         rd({3'h0, k >= 5, k >= 3}, k, k);
         pulse(2, k);
         pulse(1, k);
         rd({3'h0, k > 5, k > 3}, 0, 0);
      end
      pulse(0, 1);
      wsave = wd;
      pulse(2, 1);
      `CHK(cin_d, wsave)
      pulse(3, 1);
      wsave = wd;
      pulse(1, 1);
      `CHK(cout_d, wsave)
      $display("test levels done");
      pulse(0, 4);
      rd(5'h01, 4, 0);
      dma_go <= 1'b1;
      pulse(2, 1);
      wait_idle();
      rd(5'h00, 8, 0);
      dma_wait <= 4'h7;
      pulse(3, 5);
      wait_idle();
      rd(5'h00, 8, 0);
      $display("test dma done");
      final_report();
   end
endmodule // cvsd_pcm_status_flags_tb
bind cvsd_pcm_status_flags cvsd_pcm_status_flags_sva u_cvsd_pcm_status_flags_sva (
   .i_clock, .i_rstn, .i_converter_enable, .i_freeze, .i_fifo_level_irq_enable,
   .i_fifo_error_irq_enable, .i_pcm_irq_enable, .i_in_fifo_dma_enable, .i_out_fifo_dma_enable,
   .i_status_rd, .o_converter_status, .i_cvsd_in_wr, .i_core_in_rd, .i_core_pcm_out_wr,
   .o_irq, .o_in_fifo_dma_req, .o_out_fifo_dma_req);
`default_nettype wire

// ---- verification/dma_host_model.sv ----
// Purpose: Processor and DMA controller on the peripheral bus side
// Assumes: Requests are levels; status read strobe lasts one cycle
// Notes:   Burst length is taken from the count fields, never the flags
`timescale 1ns/1ps
`default_nettype none
module dma_host_model (
   input  wire logic        i_clock,
   input  wire logic        i_go,
   input  wire logic [3:0]  i_wait,
   input  wire logic        i_in_req,
   input  wire logic        i_out_req,
   input  wire logic [15:0] i_status,
   output var  logic        o_push,
   output var  logic        o_pop,
   output var  logic        o_status_rd
);
   // ---------------------------------------------------------------
   // Service loop
   // ---------------------------------------------------------------
   logic       sel;
   logic [2:0] n;
   initial
   begin
      o_push      = 1'b0;
      o_pop       = 1'b0;
      o_status_rd = 1'b0;
      forever
      begin
         @(posedge i_clock);
         if (i_go && (i_in_req || i_out_req))
         begin
            // Input side first: a starved input stream is heard sooner
            sel = i_in_req;
            n   = sel ? i_status[7:5] : i_status[10:8];
            repeat (i_wait) @(posedge i_clock);
            repeat (n)
            begin
               o_push <= sel;
               o_pop  <= !sel;
               @(posedge i_clock);
            end
            o_push      <= 1'b0;
            o_pop       <= 1'b0;
            o_status_rd <= 1'b1;
            @(posedge i_clock);
            o_status_rd <= 1'b0;
            @(posedge i_clock);
         end
      end
   end
endmodule // dma_host_model
`default_nettype wire
